/* lsi_map.svh */
// register layout, command codes and address of the light sensor slave
`ifndef LSI_MAP_SVH
`define LSI_MAP_SVH
`define LSI_SLAVE_ADDR      7'h29
`define LSI_CMD_RESET       8'h80
`define LSI_CMD_SHUTDOWN_BIT 7
`define LSI_CMD_ACTIVATE    8'h04
`define LSI_CMD_START       8'h08
`define LSI_CMD_STOP        8'h30
`define LSI_VALID_BIT       15
`define LSI_COUNT_MSB       14
`define LSI_RESULT_RESET    16'h0000
`endif

/* lsi_pkg.sv */
// types shared by the light sensor slave
package lsi_pkg;
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_ADDR,
      ST_ADDR_ACK,
      ST_WDATA,
      ST_WACK,
      ST_RDATA,
      ST_RACK,
      ST_IGNORE
   } lsi_state_e;

   // state on the bus clock side
   typedef struct packed {
      logic [2:0] scl_sync;
      logic [2:0] sda_sync;
      lsi_state_e state;
      logic [3:0] bit_cnt;
      logic [7:0] shift;
      logic       byte_idx;
      logic       sda_oe;
      logic [7:0] command;
      logic       cmd_toggle;
   } lsi_bus_s;

   // state on the light pulse side
   typedef struct packed {
      logic [2:0]  cmd_toggle_sync;
      logic [7:0]  cmd_hold;
      logic        active;
      logic        integrating;
      logic        cmd_apply;
      logic [1:0]  pulse_sync;
      logic        pulse_prev;
      logic [14:0] count;
      logic [15:0] result;
   } lsi_lite_s;
endpackage

/* lsi_light_slave.sv */
// two-wire slave and integrating light counter of the ambient sensor
//
// Behaviour
// - eight-bit command register, writable and readable
// - read-only two-byte result holds latest count
// - respond only to address 0101001
// - send byte, receive byte, receive word
// - send byte data stored as command
// - acknowledge own address by pulling data low
// - acknowledge written data byte, master stops
// - read drives eight bits, msb first
// - word read returns both result bytes
// - result is 15-bit count plus valid
// - count bits 0 to 14, valid bit 15
// - high byte 15..8, low byte 7..0
// - 15-bit counter accumulates light pulses
// - shut-down at reset and on top bit
// - 0x04 activates the sensor
// - 0x08 clears result, starts integration, only once activated
// - 0x30 stops integration, sets valid
`include "lsi_map.svh"
`timescale 1ns/1ns
`default_nettype none
module lsi_light_slave
(
   // system
   input  wire logic SYS_CLK,
   input  wire logic RESET,
   input  wire logic CLK_EN,
   // light pulse domain
   input  wire logic LIGHT_CLK,
   input  wire logic LIGHT_PULSE,
   // two-wire bus pins
   input  wire logic SCL_IN,
   input  wire logic SDA_IN,
   output logic      SDA_OUT,
   output logic      SDA_OE,
   // status
   output logic [7:0]  COMMAND,
   output logic [15:0] RESULT
);
   // ==================================================================
   // bus side and light side state
   lsi_pkg::lsi_bus_s  r;
   lsi_pkg::lsi_bus_s  next_r;
   lsi_pkg::lsi_lite_s l;
   lsi_pkg::lsi_lite_s next_l;

   // result word synchroniser, its stability copy and the taken word
   logic [15:0] res_sync1;
   logic [15:0] res_sync2;
   logic [15:0] res_seen;
   logic [15:0] res_sync3;

   logic scl, scl_d, sda, sda_d;
   logic scl_rise, scl_fall, start_det, stop_det;

   always_comb
   begin
      scl       = r.scl_sync[1];
      scl_d     = r.scl_sync[2];
      sda       = r.sda_sync[1];
      sda_d     = r.sda_sync[2];
      scl_rise  = scl & ~scl_d;
      scl_fall  = ~scl & scl_d;
      start_det = scl & scl_d & sda_d & ~sda;
      stop_det  = scl & scl_d & ~sda_d & sda;
   end

   // ==================================================================
   // bus protocol engine
   always_comb
   begin
      next_r = r;
      next_r.scl_sync = {r.scl_sync[1:0], SCL_IN};
      next_r.sda_sync = {r.sda_sync[1:0], SDA_IN};
      if (start_det)
      begin
         next_r.state   = lsi_pkg::ST_ADDR;
         next_r.bit_cnt = 4'h0;
         next_r.sda_oe  = 1'b0;
      end
      else if (stop_det)
      begin
         next_r.state  = lsi_pkg::ST_IDLE;
         next_r.sda_oe = 1'b0;
      end
      else
      begin
         unique case (r.state)
            lsi_pkg::ST_IDLE, lsi_pkg::ST_IGNORE:
            begin
               next_r.sda_oe = 1'b0;
            end
            lsi_pkg::ST_ADDR, lsi_pkg::ST_WDATA:
            begin
               if (scl_rise)
               begin
                  next_r.shift   = {r.shift[6:0], sda};
                  next_r.bit_cnt = r.bit_cnt + 4'h1;
               end
               if (scl_fall && r.bit_cnt == 4'h8)
               begin
                  next_r.bit_cnt = 4'h0;
                  if (r.state == lsi_pkg::ST_WDATA)
                  begin
                     next_r.command    = r.shift;
                     next_r.cmd_toggle = ~r.cmd_toggle;
                     next_r.sda_oe     = 1'b1;
                     next_r.state      = lsi_pkg::ST_WACK;
                  end
                  else if (r.shift[7:1] == `LSI_SLAVE_ADDR)
                  begin
                     next_r.sda_oe   = 1'b1;
                     next_r.byte_idx = 1'b0;
                     next_r.state    = lsi_pkg::ST_ADDR_ACK;
                  end
                  else
                  begin
                     next_r.state = lsi_pkg::ST_IGNORE;
                  end
               end
            end
            lsi_pkg::ST_ADDR_ACK:
            begin
               if (scl_fall)
               begin
                  if (r.shift[0])
                  begin
                     // every read shows the command first; further acked bytes show the result
                     next_r.shift = r.command;
                     next_r.state = lsi_pkg::ST_RDATA;
                     next_r.sda_oe = ~r.command[7];
                  end
                  else
                  begin
                     next_r.sda_oe = 1'b0;
                     next_r.state  = lsi_pkg::ST_WDATA;
                  end
               end
            end
            lsi_pkg::ST_WACK:
            begin
               if (scl_fall)
               begin
                  next_r.sda_oe = 1'b0;
                  next_r.state  = lsi_pkg::ST_IGNORE;
               end
            end
            lsi_pkg::ST_RDATA:
            begin
               if (scl_fall)
               begin
                  if (r.bit_cnt == 4'h7)
                  begin
                     next_r.sda_oe = 1'b0;
                     next_r.state  = lsi_pkg::ST_RACK;
                  end
                  else
                  begin
                     next_r.bit_cnt = r.bit_cnt + 4'h1;
                     next_r.shift   = {r.shift[6:0], 1'b0};
                     next_r.sda_oe  = ~r.shift[6];
                  end
               end
            end
            lsi_pkg::ST_RACK:
            begin
               if (scl_rise)
               begin
                  // nack ends the read; ack asks for the next byte
                  next_r.bit_cnt = 4'h0;
                  if (sda)
                  begin
                     next_r.state = lsi_pkg::ST_IGNORE;
                  end
                  else
                  begin
                     next_r.byte_idx = ~r.byte_idx;
                     // low byte first, then high byte
                     next_r.shift = r.byte_idx ? res_sync3[15:8]
                                               : res_sync3[7:0];
                  end
               end
               if (scl_fall && r.state == lsi_pkg::ST_RACK && !sda_d)
               begin
                  next_r.state  = lsi_pkg::ST_RDATA;
                  next_r.sda_oe = ~r.shift[7];
               end
            end
         endcase
      end
   end

   // ==================================================================
   // bus state registers
   // the lines idle high, so the synchronisers start high and no false
   // start or stop follows reset
   always_ff @(posedge SYS_CLK or posedge RESET)
   begin
      if (RESET)
      begin
         r.scl_sync   <= 3'h7;
         r.sda_sync   <= 3'h7;
         r.state      <= lsi_pkg::ST_IDLE;
         r.bit_cnt    <= 4'h0;
         r.shift      <= 8'h00;
         r.byte_idx   <= 1'b0;
         r.sda_oe     <= 1'b0;
         r.command    <= `LSI_CMD_RESET;
         r.cmd_toggle <= 1'b0;
      end
      else if (CLK_EN)
      begin
         r <= next_r;
      end
   end

   // ==================================================================
   // result word into the bus clock domain
   // the word moves only on commands, so a copy that matched on two
   // edges is taken whole; a word caught mid-change is never shown
   always_ff @(posedge SYS_CLK or posedge RESET)
   begin
      if (RESET)
      begin
         res_sync1 <= `LSI_RESULT_RESET;
         res_sync2 <= `LSI_RESULT_RESET;
         res_seen  <= `LSI_RESULT_RESET;
         res_sync3 <= `LSI_RESULT_RESET;
      end
      else if (CLK_EN)
      begin
         res_sync1 <= l.result;
         res_sync2 <= res_sync1;
         res_seen  <= res_sync2;
         if (res_sync2 == res_seen)
         begin
            res_sync3 <= res_sync2;
         end
      end
   end

   // ==================================================================
   // output registers
   always_ff @(posedge SYS_CLK or posedge RESET)
   begin
      if (RESET)
      begin
         SDA_OUT <= 1'b0;
         SDA_OE  <= 1'b0;
         COMMAND <= `LSI_CMD_RESET;
         RESULT  <= `LSI_RESULT_RESET;
      end
      else if (CLK_EN)
      begin
         // open drain: the level stays low, only the enable moves
         SDA_OUT <= 1'b0;
         SDA_OE  <= next_r.sda_oe;
         COMMAND <= next_r.command;
         RESULT  <= res_sync3;
      end
   end

   // ==================================================================
   // light pulse integration domain
   // the command word is captured only once its toggle has passed the
   // synchroniser, so it has long stopped moving; decoding from the
   // held copy a cycle later keeps the wide word off the decode path
   logic cmd_new;
   logic pulse_now;
   logic pulse_edge;

   always_comb
   begin
      cmd_new    = l.cmd_toggle_sync[2] ^ l.cmd_toggle_sync[1];
      pulse_now  = l.pulse_sync[1];
      pulse_edge = pulse_now & ~l.pulse_prev;
      next_l                 = l;
      next_l.cmd_toggle_sync = {l.cmd_toggle_sync[1:0], r.cmd_toggle};
      next_l.pulse_sync      = {l.pulse_sync[0], LIGHT_PULSE};
      next_l.pulse_prev      = pulse_now;
      next_l.cmd_apply       = cmd_new;
      if (cmd_new)
      begin
         next_l.cmd_hold = r.command;
      end
      if (l.cmd_apply)
      begin
         if (l.cmd_hold[`LSI_CMD_SHUTDOWN_BIT])
         begin
            // shut-down keeps the last result readable
            next_l.active      = 1'b0;
            next_l.integrating = 1'b0;
         end
         else if (l.cmd_hold == `LSI_CMD_ACTIVATE)
         begin
            next_l.active = 1'b1;
         end
         else if (l.cmd_hold == `LSI_CMD_START && l.active)
         begin
            next_l.count       = 15'h0000;
            next_l.result      = `LSI_RESULT_RESET;
            next_l.integrating = 1'b1;
         end
         else if (l.cmd_hold == `LSI_CMD_STOP && l.integrating)
         begin
            next_l.integrating = 1'b0;
            next_l.result      = {1'b1, l.count};
         end
      end
      else if (l.integrating && pulse_edge)
      begin
         // saturate: a long window must not wrap to a small count
         if (l.count != 15'h7fff)
         begin
            next_l.count = l.count + 15'h0001;
         end
      end
   end

   // ==================================================================
   // light domain registers
   always_ff @(posedge LIGHT_CLK or posedge RESET)
   begin
      if (RESET)
      begin
         l.cmd_toggle_sync <= 3'h0;
         l.cmd_hold        <= `LSI_CMD_RESET;
         l.cmd_apply       <= 1'b0;
         l.active          <= 1'b0;
         l.integrating     <= 1'b0;
         l.pulse_sync      <= 2'h0;
         l.pulse_prev      <= 1'b0;
         l.count           <= 15'h0000;
         l.result          <= `LSI_RESULT_RESET;
      end
      else if (CLK_EN)
      begin
         l <= next_l;
      end
   end
endmodule
`default_nettype wire

/* lsi_properties.sv */
// port assertions for the light sensor slave
`timescale 1ns/1ns
`default_nettype none
module lsi_properties
(
   // system
   input wire logic        SYS_CLK,
   input wire logic        RESET,
   // bus
   input wire logic        SCL_IN,
   input wire logic        SDA_OUT,
   input wire logic        SDA_OE,
   // status
   input wire logic [7:0]  COMMAND,
   input wire logic [15:0] RESULT
);
   // ==========================================
   // checks
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (RESET);
   property p_low; SDA_OE |-> !SDA_OUT; endproperty
   a_low: assert property (p_low) else $error("sda high");
   // slave may only move the line while the clock is low
   property p_edge; $changed(SDA_OE) |-> !$past(SCL_IN, 2); endproperty
   a_edge: assert property (p_edge) else $error("oe edge");
   property p_hold; SCL_IN [*6] |-> $stable(SDA_OE); endproperty
   a_hold: assert property (p_hold) else $error("oe moved");
   property p_valid; $rose(RESULT[15]) |-> COMMAND == 8'h30; endproperty
   a_valid: assert property (p_valid) else $error("valid");
   property p_zero;
      $changed(RESULT) && RESULT == 16'h0000 |-> COMMAND == 8'h08;
   endproperty
   a_zero: assert property (p_zero) else $error("clear");
   property p_frozen; RESULT[15] && $past(RESULT[15]) |-> $stable(RESULT);
   endproperty
   a_frozen: assert property (p_frozen) else $error("frozen");
   property p_rst;
      $fell(RESET) |-> !SDA_OE && COMMAND == 8'h80 && RESULT == 16'h0000;
   endproperty
   a_rst: assert property (p_rst) else $error("reset");
   // a count only ever appears together with its valid flag
   property p_grow;
      $changed(RESULT) && RESULT != 16'h0000 |-> RESULT[15];
   endproperty
   a_grow: assert property (p_grow) else $error("count");
   c_valid: cover property ($rose(RESULT[15]));
   c_ack: cover property ($rose(SDA_OE));
   c_act: cover property (COMMAND == 8'h04);
endmodule
`default_nettype wire

/* lsi_bus_master.sv */
// two-wire bus master model facing the sensor
`timescale 1ns/1ns
`default_nettype none
module lsi_bus_master
(
   // bus lines
   output logic      SCL,
   output logic      SDA_LOW,
   input  wire logic SDA
);
   // ==========================================
   // bit engine
   // multiples of 10 keep edges off the system clock edge
   localparam int H = 520;
   initial
   begin
      SCL = 1'b1;
      SDA_LOW = 1'b0;
   end
   task start;
      SDA_LOW = 1'b1;
      #H SCL = 1'b0;
   endtask
   // data waits an eighth of a bit after the fall: no false start or stop
   task bitx(input logic b, output logic r);
      #(H/4) SDA_LOW = !b;
      #(H*3/4) SCL = 1'b1;
      #(H/2) r = SDA;
      #(H/2) SCL = 1'b0;
   endtask
   task stop;
      #(H/4) SDA_LOW = 1'b1;
      #(H*3/4) SCL = 1'b1;
      #H SDA_LOW = 1'b0;
      #H;
   endtask
   task wbyte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--)
         bitx(d[i], r);
      bitx(1'b1, ack);
   endtask
   task rbyte(input logic nack, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--)
      begin
         bitx(1'b1, r);
         d[i] = r;
      end
      bitx(nack, r);
   endtask
endmodule
`default_nettype wire

/* tb_top.sv */
// self-checking bench for the light sensor slave
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   // ==========================================
   // harness
   logic        sys_clk = 0;
   logic        reset = 1;
   logic        lclk = 0;
   logic        pulse = 0;
   logic        scl, m_low, sda_out, sda_oe, ak;
   logic [7:0]  command, c, l, h;
   logic [15:0] result;
   int          n_fail = 0;
   int          comparisons = 0;
   logic [7:0]  rows [4] = '{8'h85, 8'hff, 8'h30, 8'h04};
   // pull-up: a released line reads high
   wire         sda = !(m_low || (sda_oe && !sda_out));
   always #5 sys_clk = ~sys_clk;
   always
   begin
      #7;
      forever #15 lclk = ~lclk;
   end
   lsi_light_slave dut (.SYS_CLK(sys_clk), .RESET(reset), .CLK_EN(1'b1),
      .LIGHT_CLK(lclk), .LIGHT_PULSE(pulse), .SCL_IN(scl), .SDA_IN(sda),
      .SDA_OUT(sda_out), .SDA_OE(sda_oe), .COMMAND(command),
      .RESULT(result));
   lsi_bus_master u_mst (.SCL(scl), .SDA_LOW(m_low), .SDA(sda));
   task cmp(input string nm, input logic [15:0] e, input logic [15:0] s);
      comparisons++;
      if (s !== e)
      begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", nm, e, s);
      end
   endtask
   task addr(input logic rd);
      u_mst.start();
      u_mst.wbyte({7'h29, rd}, ak);
      cmp("addr ack", 16'h0000, {15'h0, ak});
   endtask
   task send(input logic [7:0] d);
      addr(1'b0);
      u_mst.wbyte(d, ak);
      cmp("data ack", 16'h0000, {15'h0, ak});
      u_mst.stop();
      cmp("command", {8'h00, d}, {8'h00, command});
   endtask
   task rd_byte(input logic [7:0] e);
      addr(1'b1);
      u_mst.rbyte(1'b1, c);
      u_mst.stop();
      cmp("byte", {8'h00, e}, {8'h00, c});
   endtask
   task rd_word(input logic [7:0] e, input logic [15:0] w);
      addr(1'b1);
      u_mst.rbyte(1'b0, c);
      u_mst.rbyte(1'b0, l);
      u_mst.rbyte(1'b1, h);
      u_mst.stop();
      cmp("word cmd", {8'h00, e}, {8'h00, c});
      cmp("word", w, {h, l});
   endtask
   task final_report;
      $display("comparisons %0d n_fail %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // ==========================================
   // tests
   initial
   begin
      #700000;
      n_fail++;
      final_report();
   end
   initial
   begin
      repeat (10) @(posedge sys_clk);
      #1 reset = 0;
      repeat (10) @(posedge sys_clk);
      #1;
      cmp("rst cmd", 16'h0080, {8'h00, command});
      cmp("rst result", 16'h0000, result);
      rd_byte(8'h80);
      $display("reset test done");
      foreach (rows[i])
      begin
         send(rows[i]);
         rd_byte(rows[i]);
      end
      $display("command table done");
      u_mst.start();
      u_mst.wbyte({7'h2a, 1'b0}, ak);
      cmp("foreign ack", 16'h0001, {15'h0, ak});
      u_mst.wbyte(8'h55, ak);
      u_mst.stop();
      cmp("foreign cmd", 16'h0004, {8'h00, command});
      $display("address test done");
      send(8'h08);
      #2000;
      // exactly 100 rising edges inside the window
      repeat (100)
      begin
         @(posedge lclk) #1 pulse = 1;
         @(posedge lclk) #1 pulse = 0;
      end
      #2000;
      send(8'h30);
      rd_word(8'h30, 16'h8064);
      cmp("result", 16'h8064, result);
      send(8'h08);
      rd_word(8'h08, 16'h0000);
      send(8'h80);
      rd_byte(8'h80);
      $display("integration test done");
      final_report();
   end
endmodule
bind lsi_light_slave lsi_properties u_prop (.SYS_CLK(SYS_CLK),
   .RESET(RESET), .SCL_IN(SCL_IN), .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE),
   .COMMAND(COMMAND), .RESULT(RESULT));
`default_nettype wire
